// ===== hw/tib_tap.sv
// Test access port: controller, instruction register and bypass register
`timescale 1ns/1ns
module tib_tap
  import tib_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe_n,
  output logic bypass_sel,
  output logic [7:0] dr_parallel
);
  import tib_pkg::*;

  tib_regs_type cur_r;
  tib_regs_type cur_nxt;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic rise;
  logic fall;

  function automatic tib_state_type next_state(input tib_state_type s, input logic m);
    unique case (s)
      TS_RESET: next_state = m ? TS_RESET : TS_IDLE;
      TS_IDLE: next_state = m ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: next_state = m ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: next_state = m ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: next_state = m ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: next_state = m ? TS_UPD_DR : TS_PAUSE_DR;
      TS_PAUSE_DR: next_state = m ? TS_EX2_DR : TS_PAUSE_DR;
      TS_EX2_DR: next_state = m ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: next_state = m ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: next_state = m ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: next_state = m ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: next_state = m ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: next_state = m ? TS_UPD_IR : TS_PAUSE_IR;
      TS_PAUSE_IR: next_state = m ? TS_EX2_IR : TS_PAUSE_IR;
      TS_EX2_IR: next_state = m ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: next_state = m ? TS_SEL_DR : TS_IDLE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Second synchroniser stage only feeds logic
  assign tck_s = cur_r.tck_sync[1];
  assign tms_s = cur_r.tms_sync[1];
  assign tdi_s = cur_r.tdi_sync[1];
  assign rise = tck_s & ~cur_r.tck_prev;
  assign fall = ~tck_s & cur_r.tck_prev;

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.tck_sync = {cur_r.tck_sync[0], tck};
    cur_nxt.tms_sync = {cur_r.tms_sync[0], tms};
    cur_nxt.tdi_sync = {cur_r.tdi_sync[0], tdi};
    cur_nxt.tck_prev = tck_s;
    if (rise) begin
      unique case (cur_r.state)
        TS_RESET: cur_nxt.ir_cur = IR_RESET;
        TS_CAP_IR: cur_nxt.ir_shift = IR_CAPTURE;
        // Shift happens in the state, including the rise that leaves it
        TS_SH_IR: cur_nxt.ir_shift = {tdi_s, cur_r.ir_shift[7:1]};
        TS_UPD_IR: cur_nxt.ir_cur = cur_r.ir_shift;
        TS_CAP_DR: cur_nxt.bypass = BYPASS_CAPTURE;
        TS_SH_DR: cur_nxt.bypass = tdi_s;
        TS_UPD_DR: cur_nxt.dr_par = {DR_PAD, cur_r.bypass};
        default: ;
      endcase
      cur_nxt.state = next_state(cur_r.state, tms_s);
    end
    if (fall) begin
      // Output stage follows state on the falling edge, as the pin does
      unique case (cur_r.state)
        TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PAUSE_IR, TS_EX2_IR: begin
          cur_nxt.tdo_oe_n = 1'b0;
          cur_nxt.tdo_out = cur_r.ir_shift[0];
        end
        TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAUSE_DR, TS_EX2_DR: begin
          cur_nxt.tdo_oe_n = 1'b0;
          cur_nxt.tdo_out = (cur_r.ir_cur == IR_BYPASS) ? cur_r.bypass : 1'b0;
        end
        default: begin
          cur_nxt.tdo_oe_n = 1'b1;
          cur_nxt.tdo_out = 1'b0;
        end
      endcase
    end
    // Instruction falls back to bypass on the clock after reset state is entered, and on each clock spent there
    if (cur_r.state == TS_RESET) begin
      cur_nxt.ir_cur = IR_RESET;
    end
    // Decoded from the next value so the flag moves with the instruction
    cur_nxt.byp_sel = (cur_nxt.ir_cur == IR_BYPASS);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '{
        tck_sync: SYNC_ZERO,
        tms_sync: SYNC_ONE,
        tdi_sync: SYNC_ZERO,
        tck_prev: 1'b0,
        state: TS_RESET,
        ir_shift: IR_CAPTURE,
        ir_cur: IR_RESET,
        bypass: BYPASS_CAPTURE,
        dr_par: DR_RESET,
        byp_sel: 1'b1,
        tdo_out: 1'b0,
        tdo_oe_n: 1'b1
      };
    end else if (clk_en) begin
      cur_r <= cur_nxt;
    end
  end

  assign tdo_out = cur_r.tdo_out;
  assign tdo_oe_n = cur_r.tdo_oe_n;
  assign bypass_sel = cur_r.byp_sel;
  assign dr_parallel = cur_r.dr_par;

  ////////////////////////////////////////////////////////////////////////
  chk_ir_capture_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && rise && cur_r.state == TS_CAP_IR) |=> cur_r.ir_shift == IR_CAPTURE)
    else $error("IR capture pattern not loaded");
  chk_ir_shift_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && rise && cur_r.state == TS_SH_IR)
      |=> cur_r.ir_shift == {$past(tdi_s), $past(cur_r.ir_shift[7:1])})
    else $error("IR did not shift one bit");
  chk_bypass_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && rise && cur_r.state == TS_UPD_IR && cur_r.ir_shift == IR_BYPASS) |=> bypass_sel)
    else $error("All-ones not decoded as bypass");
  chk_upd_ir_hiz: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && fall && cur_r.state == TS_UPD_IR) |=> tdo_oe_n)
    else $error("Output not released in Update-IR");
  chk_cap_dr_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && rise && cur_r.state == TS_CAP_DR) |=> !cur_r.bypass)
    else $error("Bypass did not capture zero");
  chk_bypass_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && fall && cur_r.state == TS_SH_DR && bypass_sel) |=> tdo_out == $past(cur_r.bypass))
    else $error("Bypass output mismatch");
  chk_upd_dr_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && rise && cur_r.state == TS_UPD_DR) |=> dr_parallel[0] == $past(cur_r.bypass))
    else $error("Parallel stage not updated");
  chk_tdo_on_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!(clk_en && fall)) |=> $stable(tdo_out) && $stable(tdo_oe_n))
    else $error("Output changed off falling edge");
  chk_reset_path: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && rise && tms_s && cur_r.state == TS_SEL_IR) |=> cur_r.state == TS_RESET)
    else $error("Select-IR with mode high missed reset");

  chk_tlr_ir_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && cur_r.state == TS_RESET) |=> cur_r.ir_cur == IR_RESET)
    else $error("Reset state did not restore bypass");

  chk_bypsel_track: assert property (@(posedge core_clk) disable iff (!rst_n)
    bypass_sel == (cur_r.ir_cur == IR_BYPASS))
    else $error("Bypass flag out of step with instruction");

  chk_cap_ir_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && fall && cur_r.state == TS_CAP_IR) |=> !tdo_oe_n)
    else $error("Output not enabled in Capture-IR");

  chk_cap_dr_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && fall && cur_r.state == TS_CAP_DR) |=> !tdo_oe_n)
    else $error("Output not enabled in Capture-DR");

  chk_nonbyp_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && fall && cur_r.state == TS_SH_DR && !bypass_sel) |=> !tdo_out)
    else $error("Data shift output not low without bypass");

  chk_upd_dr_hiz: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && fall && cur_r.state == TS_UPD_DR) |=> tdo_oe_n)
    else $error("Output not released in Update-DR");

  chk_ir_first_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && rise && cur_r.state == TS_CAP_IR && !tms_s) |=> cur_r.state == TS_SH_IR)
    else $error("Capture-IR did not enter shift");

  // Clock enable low must hold every bit, synchronisers included
  chk_freeze_state: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en |=> $stable(cur_r))
    else $error("State moved while clock enable low");

  chk_state_on_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(clk_en && rise) |=> $stable(cur_r.state))
    else $error("Controller moved without test clock rise");

  chk_ir_hold_shift: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(clk_en && rise) |=> $stable(cur_r.ir_shift))
    else $error("Instruction shifter moved without rise");

  chk_upd_ir_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && rise && cur_r.state == TS_UPD_IR) |=> cur_r.ir_cur == $past(cur_r.ir_shift))
    else $error("Update-IR did not load instruction");

  cov_nonbyp_dr: cover property (@(posedge core_clk) cur_r.state == TS_SH_DR && !bypass_sel);
  cov_freeze: cover property (@(posedge core_clk) !clk_en && cur_r.state == TS_RESET);
  cov_ir_scan: cover property (@(posedge core_clk) cur_r.state == TS_UPD_IR && bypass_sel);
  cov_dr_shift: cover property (@(posedge core_clk) cur_r.state == TS_SH_DR && !tdo_oe_n);
  cov_back_reset: cover property (@(posedge core_clk)
    $past(cur_r.state) == TS_SEL_IR && cur_r.state == TS_RESET);
endmodule

// ===== hw/tib_pkg.sv
// Constants and types for the test port instruction and bypass scan block
package tib_pkg;
  localparam int IR_WIDTH = 8;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] IR_BYPASS = 8'hFF;
  localparam logic [7:0] IR_RESET = 8'hFF;
  localparam logic BYPASS_CAPTURE = 1'h0;
  localparam logic [1:0] SYNC_ZERO = 2'h0;
  localparam logic [1:0] SYNC_ONE = 2'h3;
  localparam logic [7:0] DR_RESET = 8'h00;
  localparam logic [6:0] DR_PAD = 7'h00;

  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAUSE_DR,
    TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PAUSE_IR,
    TS_EX2_IR, TS_UPD_IR
  } tib_state_type;

  typedef struct packed {
    logic [1:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    logic tck_prev;
    tib_state_type state;
    logic [7:0] ir_shift;
    logic [7:0] ir_cur;
    logic bypass;
    logic [7:0] dr_par;
    logic byp_sel;
    logic tdo_out;
    logic tdo_oe_n;
  } tib_regs_type;
endpackage

// ===== bench/tib_tester_model.sv
// Tester model: drives test clock, mode select and serial input
`timescale 1ns/1ns
module tib_tester_model (
  input wire logic core_clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe_n
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // Pins change with the fall and hold through the rise
  task automatic step(input logic m, input logic d, output logic q, output logic z);
    tck <= 1'h0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge core_clk);
    tck <= 1'h1;
    repeat (3) @(posedge core_clk);
    // Sampled late in the period so the output of this fall has settled
    @(negedge core_clk);
    q = tdo_out;
    z = tdo_oe_n;
    @(posedge core_clk);
  endtask
endmodule

// ===== bench/test_tib_tap.sv
// Random instruction and bypass scans through the test port
`timescale 1ns/1ns
module test_tib_tap;
  import tib_pkg::*;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic clk_en = 1'h1;
  logic tck, tms, tdi, tdo_out, tdo_oe_n, bypass_sel;
  logic [7:0] dr_parallel;
  int failures = 0;
  int check_count = 0;
  logic q [0:40];
  logic z [0:40];
  always #25 core_clk = ~core_clk;
  tib_tap i_tib_tap (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .bypass_sel(bypass_sel),
    .dr_parallel(dr_parallel));
  tib_tester_model i_tib_tester_model (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n));
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // IR scan of iv, DR scan of n bits, then five ones back to reset
  task automatic scan(input logic [7:0] iv, input int n, input logic [7:0] d);
    logic [40:0] m;
    logic [40:0] t;
    logic byp;
    byp = (iv == IR_BYPASS);
    m = 41'h7006;
    t = 41'({$urandom, $urandom});
    t[12:5] = iv;
    for (int k = 0; k < n; k++) t[17 + k] = d[k];
    for (int k = 16 + n; k < 21 + n; k++) m[k] = 1'h1;
    for (int j = 0; j < 21 + n; j++) begin
      i_tib_tester_model.step(m[j], t[j], q[j], z[j]);
      if (j == 15) check("bypass_sel", 8'(byp), 8'(bypass_sel));
    end
    for (int k = 0; k < 8; k++) check("ir_out", 8'(IR_CAPTURE[k]), 8'(q[5 + k]));
    check("ir_upd_oe_n", 8'h1, 8'(z[14]));
    check("dr_cap_oe_n", 8'h0, 8'(z[16]));
    for (int k = 0; k < n; k++) check("dr_out", 8'(byp && k > 0 && d[k - 1]), 8'(q[17 + k]));
    check("dr_upd_oe_n", 8'h1, 8'(z[18 + n]));
    if (byp) check("dr_parallel", 8'(d[n - 1]), dr_parallel);
    repeat (4) @(posedge core_clk);
    check("bypass_sel_tlr", 8'h1, 8'(bypass_sel));
  endtask
  initial begin
    logic [7:0] iv;
    int n;
    void'($urandom(78));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    check("bypass_sel_reset", 8'h1, 8'(bypass_sel));
    for (int r = 0; r < 6; r++) begin
      iv = (r == 0) ? IR_BYPASS : (r == 1) ? 8'hFE : (r[0] ? IR_BYPASS : 8'($urandom));
      n = (r == 0) ? 3 : 1 + int'($urandom % 8);
      scan(iv, n, (r == 0) ? 8'h05 : 8'($urandom));
      $display("test %0d instruction %h bits %0d done", r, iv, n);
      clk_en <= 1'h0;
      repeat (3) @(posedge core_clk);
      clk_en <= 1'h1;
      @(posedge core_clk);
      check("freeze_hold", 8'h1, 8'(bypass_sel));
    end
    stop_test();
  end
endmodule
